// File: prs_pkg.sv
// Package with constants for the page response and stall resume command unit.
package prs_pkg;
	localparam logic [7:0] PRS_OP_PAGE_RESP = 8'h41;
	localparam logic [7:0] PRS_OP_RESUME = 8'h44;
	localparam logic [1:0] PRS_RESP_FAIL = 2'h0;
	localparam logic [1:0] PRS_RESP_INVALID = 2'h1;
	localparam logic [1:0] PRS_RESP_SUCCESS = 2'h2;
	localparam logic [1:0] PRS_RESP_RSVD = 2'h3;
	localparam logic [1:0] PRS_STALL_UNSUPP = 2'h1;
	// Command word field positions.
	localparam int PRS_OPC_LSB = 0;
	localparam int PRS_SSV_BIT = 11;
	localparam int PRS_SEC_BIT = 10;
	localparam int PRS_SUB_LSB = 12;
	localparam int PRS_SID_LSB = 32;
	localparam int PRS_TAG_LSB = 64;
	localparam int PRS_GRP_LSB = 64;
	localparam int PRS_RSP_LSB = 76;
	localparam int PRS_ACT_BIT = 76;
	localparam int PRS_ABT_BIT = 77;
	// APB byte offsets of the unit's registers.
	localparam logic [7:0] PRS_A_CMD0 = 8'h00;
	localparam logic [7:0] PRS_A_CMD1 = 8'h04;
	localparam logic [7:0] PRS_A_CMD2 = 8'h08;
	localparam logic [7:0] PRS_A_CMD3 = 8'h0C;
	localparam logic [7:0] PRS_A_ISSUE = 8'h10;
	localparam logic [7:0] PRS_A_CFG = 8'h14;
	localparam logic [7:0] PRS_A_STAT = 8'h18;
	localparam logic [7:0] PRS_A_LAST = 8'h1C;
	// Configuration register bit positions.
	localparam int PRS_C_PRI = 0;
	localparam int PRS_C_SECURE_ADDR_SERVICES_MASK = 1;
	localparam int PRS_C_SYSPRI = 2;
	localparam int PRS_C_EN = 3;
	localparam int PRS_C_PASID = 4;
	localparam int PRS_C_TERM = 5;
	localparam int PRS_C_STALL = 6;
	localparam int PRS_C_SECIMPL = 8;
	localparam logic [31:0] PRS_CFG_RST = 32'h0000_0000;
	// Outcome codes of the last command.
	localparam logic [2:0] PRS_OUT_NONE = 3'h0;
	localparam logic [2:0] PRS_OUT_RESP = 3'h1;
	localparam logic [2:0] PRS_OUT_NOP = 3'h2;
	localparam logic [2:0] PRS_OUT_ILL = 3'h3;
	localparam logic [2:0] PRS_OUT_RETRY = 3'h4;
	localparam logic [2:0] PRS_OUT_TERM_OK = 3'h5;
	localparam logic [2:0] PRS_OUT_TERM_ABT = 3'h6;
	localparam logic [2:0] PRS_OUT_NOMATCH = 3'h7;
	typedef enum logic [2:0] {
		PRS_IDLE = 3'b001,
		PRS_EXEC = 3'b010,
		PRS_WAIT = 3'b100
	} prs_state_t;
endpackage : prs_pkg

// File: prs_cmd_unit.sv
// Command unit executing page group responses and stall resume commands.
`timescale 1ns/1ps
module prs_cmd_unit
	import prs_pkg::*;
#(
	parameter int SID_W = 32,
	parameter int SUB_W = 20,
	parameter int TAG_W = 4,
	parameter int GRP_W = 9
) (
	input wire logic clk, // 40 MHz clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic stallIn, // Client stall arrives
	input wire logic [TAG_W-1:0] stallInTag, // Tag slot of arriving stall
	input wire logic [SID_W-1:0] stallInSid, // Stream of arriving stall
	input wire logic stallInSec, // Security of arriving stall
	output logic pageRespValid, // Page response message valid, held until accepted
	output logic [SID_W-1:0] pageRespSid, // Target stream identifier
	output logic [GRP_W-1:0] pageRespGroup, // Page group tag
	output logic [1:0] pageRespCode, // Response code
	output logic pageRespPasid, // PASID prefix present
	output logic [SUB_W-1:0] pageRespSub, // Sub-context index
	input wire logic pageRespReady, // Root complex accepts response
	output logic resumeValid, // Resume action pulse to client
	output logic [TAG_W-1:0] resumeTag, // Stall slot resumed
	output logic resumeRetry, // Replay as new arrival
	output logic resumeAbort, // Terminate with abort, else read-zero
	output logic illegalCommandError // Illegal command error level
);
	localparam int SLOTS = 1 << TAG_W;
	logic [31:0] cmd_r [4];
	logic [31:0] cmd_nxt [4];
	logic [31:0] cfg_r, cfg_nxt;
	logic secQ_r, secQ_nxt;
	logic [2:0] out_r, out_nxt;
	logic err_r, err_nxt;
	prs_state_t st_r, st_nxt;
	logic [SLOTS-1:0] busy_r, busy_nxt;
	logic [SLOTS-1:0] sec_r, sec_nxt;
	logic [SID_W-1:0] sid_r [SLOTS];
	logic [SID_W-1:0] sid_nxt [SLOTS];
	logic pv_r, pv_nxt, rv_r, rv_nxt, rr_r, rr_nxt, ra_r, ra_nxt, pp_r, pp_nxt;
	logic [SID_W-1:0] ps_r, ps_nxt;
	logic [GRP_W-1:0] pg_r, pg_nxt;
	logic [1:0] pc_r, pc_nxt;
	logic [SUB_W-1:0] pb_r, pb_nxt;
	logic [TAG_W-1:0] rt_r, rt_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [TAG_W-1:0] sIn_r1, sIn_r2;
	logic [SID_W-1:0] sId_r1, sId_r2;
	logic sSt_r1, sSt_r2, sSe_r1, sSe_r2;
	logic [127:0] cw;
	logic [7:0] opc;
	logic [TAG_W-1:0] tag;
	logic [SID_W-1:0] sid;
	logic apbWr;
	logic freeSlot;
	logic rdy_r, rdy_nxt, serr_r, serr_nxt;

	function automatic logic cfgBit(input logic [31:0] c, input int pos);
		return c[pos];
	endfunction : cfgBit

	function automatic logic [1:0] respField(input logic [127:0] c);
		return c[PRS_RSP_LSB +: 2];
	endfunction : respField

	function automatic logic actField(input logic [127:0] c);
		return c[PRS_ACT_BIT];
	endfunction : actField

	function automatic logic secField(input logic [127:0] c);
		return c[PRS_SEC_BIT];
	endfunction : secField

	// Client stall inputs arrive from outside; two flops each.
	always_ff @(posedge clk)
	begin
		sSt_r1 <= stallIn;
		sSt_r2 <= sSt_r1;
		sIn_r1 <= stallInTag;
		sIn_r2 <= sIn_r1;
		sId_r1 <= stallInSid;
		sId_r2 <= sId_r1;
		sSe_r1 <= stallInSec;
		sSe_r2 <= sSe_r1;
	end

	assign cw = {cmd_r[3], cmd_r[2], cmd_r[1], cmd_r[0]};
	assign opc = cw[PRS_OPC_LSB +: 8];
	assign tag = cw[PRS_TAG_LSB +: TAG_W];
	assign sid = cw[PRS_SID_LSB +: SID_W];
	assign apbWr = psel && penable && pwrite;

	always_comb
	begin
		cmd_nxt = cmd_r;
		cfg_nxt = cfg_r;
		secQ_nxt = secQ_r;
		out_nxt = out_r;
		err_nxt = err_r;
		st_nxt = st_r;
		freeSlot = 1'b0;
		pv_nxt = pv_r && !pageRespReady;
		ps_nxt = ps_r;
		pg_nxt = pg_r;
		pc_nxt = pc_r;
		pp_nxt = pp_r;
		pb_nxt = pb_r;
		rv_nxt = 1'b0;
		rt_nxt = rt_r;
		rr_nxt = rr_r;
		ra_nxt = ra_r;
		if (apbWr)
		begin
			case (paddr)
				PRS_A_CMD0: cmd_nxt[0] = pwdata;
				PRS_A_CMD1: cmd_nxt[1] = pwdata;
				PRS_A_CMD2: cmd_nxt[2] = pwdata;
				PRS_A_CMD3: cmd_nxt[3] = pwdata;
				PRS_A_CFG: cfg_nxt = pwdata;
				PRS_A_ISSUE:
				begin
					if (st_r == PRS_IDLE)
					begin
						secQ_nxt = pwdata[0];
						st_nxt = PRS_EXEC;
					end
				end
				// Writing one clears the sticky error.
				PRS_A_STAT: if (pwdata[2]) err_nxt = 1'b0;
				default: ;
			endcase
		end
		case (st_r)
			PRS_IDLE: ;
			PRS_EXEC:
			begin
				st_nxt = PRS_IDLE;
				if (opc == PRS_OP_PAGE_RESP)
				begin
					if (!cfgBit(cfg_r, PRS_C_PRI) || respField(cw) == PRS_RESP_RSVD)
						out_nxt = PRS_OUT_ILL;
					else if (secQ_r && cfgBit(cfg_r, PRS_C_SECURE_ADDR_SERVICES_MASK))
						out_nxt = PRS_OUT_ILL;
					else if (!cfgBit(cfg_r, PRS_C_SYSPRI) || !cfgBit(cfg_r, PRS_C_EN))
						out_nxt = PRS_OUT_NOP;
					else
					begin
						ps_nxt = sid;
						pg_nxt = cw[PRS_GRP_LSB +: GRP_W];
						pc_nxt = respField(cw);
						pp_nxt = cw[PRS_SSV_BIT] && cfgBit(cfg_r, PRS_C_PASID);
						pb_nxt = pp_nxt ? cw[PRS_SUB_LSB +: SUB_W] : '0;
						pv_nxt = 1'b1;
						out_nxt = PRS_OUT_RESP;
						st_nxt = PRS_WAIT;
					end
				end
				else if (opc == PRS_OP_RESUME)
				begin
					if (cfg_r[PRS_C_STALL +: 2] == PRS_STALL_UNSUPP)
						out_nxt = PRS_OUT_ILL;
					else if (!secQ_r && secField(cw))
						out_nxt = PRS_OUT_ILL;
					else if (busy_r[tag] && sid_r[tag] == sid &&
						sec_r[tag] == (secQ_r && secField(cw)))
					begin
						freeSlot = 1'b1;
						rv_nxt = 1'b1;
						rt_nxt = tag;
						rr_nxt = actField(cw);
						ra_nxt = !actField(cw) &&
							(cw[PRS_ABT_BIT] || cfgBit(cfg_r, PRS_C_TERM));
						out_nxt = actField(cw) ? PRS_OUT_RETRY :
							(ra_nxt ? PRS_OUT_TERM_ABT : PRS_OUT_TERM_OK);
					end
					else
						out_nxt = PRS_OUT_NOMATCH;
				end
				else
					out_nxt = PRS_OUT_NONE;
				if (out_nxt == PRS_OUT_ILL)
					err_nxt = 1'b1;
			end
			PRS_WAIT:
				if (!pv_nxt)
					st_nxt = PRS_IDLE;
			default: st_nxt = PRS_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 4; i++)
				cmd_r[i] <= 32'h0000_0000;
			cfg_r <= PRS_CFG_RST;
			secQ_r <= 1'b0;
			out_r <= PRS_OUT_NONE;
			err_r <= 1'b0;
			st_r <= PRS_IDLE;
			pv_r <= 1'b0;
			ps_r <= '0;
			pg_r <= '0;
			pc_r <= 2'h0;
			pp_r <= 1'b0;
			pb_r <= '0;
			rv_r <= 1'b0;
			rt_r <= '0;
			rr_r <= 1'b0;
			ra_r <= 1'b0;
		end
		else
		begin
			cmd_r <= cmd_nxt;
			cfg_r <= cfg_nxt;
			secQ_r <= secQ_nxt;
			out_r <= out_nxt;
			err_r <= err_nxt;
			st_r <= st_nxt;
			pv_r <= pv_nxt;
			ps_r <= ps_nxt;
			pg_r <= pg_nxt;
			pc_r <= pc_nxt;
			pp_r <= pp_nxt;
			pb_r <= pb_nxt;
			rv_r <= rv_nxt;
			rt_r <= rt_nxt;
			rr_r <= rr_nxt;
			ra_r <= ra_nxt;
		end
	end

	// Bus response: read data is taken in the setup cycle so every access phase ends at once.
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		rdy_nxt = 1'b1;
		serr_nxt = 1'b0;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				PRS_A_CMD0: rd_nxt = cmd_r[0];
				PRS_A_CMD1: rd_nxt = cmd_r[1];
				PRS_A_CMD2: rd_nxt = cmd_r[2];
				PRS_A_CMD3: rd_nxt = cmd_r[3];
				PRS_A_CFG: rd_nxt = cfg_r;
				PRS_A_STAT: rd_nxt = {29'h0000_0000, err_r, st_r != PRS_IDLE, secQ_r};
				PRS_A_LAST: rd_nxt = {29'h0000_0000, out_r};
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rd_r <= 32'h0000_0000;
			rdy_r <= 1'b1;
			serr_r <= 1'b0;
		end
		else
		begin
			rd_r <= rd_nxt;
			rdy_r <= rdy_nxt;
			serr_r <= serr_nxt;
		end
	end

	// Stall slot table: an arrival wins over a resume that frees the same slot in one cycle.
	always_comb
	begin
		busy_nxt = busy_r;
		sec_nxt = sec_r;
		sid_nxt = sid_r;
		if (freeSlot)
			busy_nxt[tag] = 1'b0;
		if (sSt_r2)
		begin
			busy_nxt[sIn_r2] = 1'b1;
			sid_nxt[sIn_r2] = sId_r2;
			sec_nxt[sIn_r2] = sSe_r2 && cfgBit(cfg_r, PRS_C_SECIMPL);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < SLOTS; i++)
				sid_r[i] <= '0;
			busy_r <= '0;
			sec_r <= '0;
		end
		else
		begin
			busy_r <= busy_nxt;
			sec_r <= sec_nxt;
			sid_r <= sid_nxt;
		end
	end

	assign prdata = rd_r;
	assign pready = rdy_r;
	assign pslverr = serr_r;
	assign pageRespValid = pv_r;
	assign pageRespSid = ps_r;
	assign pageRespGroup = pg_r;
	assign pageRespCode = pc_r;
	assign pageRespPasid = pp_r;
	assign pageRespSub = pb_r;
	assign resumeValid = rv_r;
	assign resumeTag = rt_r;
	assign resumeRetry = rr_r;
	assign resumeAbort = ra_r;
	assign illegalCommandError = err_r;
endmodule : prs_cmd_unit

// File: prs_monitor.sv
// Port checker of the command unit.
`timescale 1ns/1ps
module prs_monitor
	import prs_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rstn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Data
	input wire logic pageRespValid, // Response
	input wire logic [1:0] pageRespCode, // Code
	input wire logic pageRespReady, // Accept
	input wire logic resumeValid, // Resume
	input wire logic resumeRetry, // Retry
	input wire logic resumeAbort, // Abort
	input wire logic illegalCommandError // Error
);
	logic wr;
	logic iss;
	assign wr = psel && penable && pwrite;
	assign iss = wr && paddr == PRS_A_ISSUE;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence failed;
		iss ##2 $rose(illegalCommandError);
	endsequence
	resp_hold_a: assert property (
		pageRespValid && !pageRespReady |=> pageRespValid && $stable(pageRespCode))
		else $error("Response dropped");
	resp_once_a: assert property (pageRespValid && pageRespReady |=> !pageRespValid)
		else $error("Response repeated");
	resp_cause_a: assert property ($rose(pageRespValid) |-> $past(iss, 2))
		else $error("Response without issue");
	code_legal_a: assert property (pageRespValid |-> pageRespCode != PRS_RESP_RSVD)
		else $error("Reserved code sent");
	resume_pulse_a: assert property (resumeValid |=> !resumeValid)
		else $error("Resume too long");
	resume_cause_a: assert property ($rose(resumeValid) |-> $past(iss, 2))
		else $error("Resume without issue");
	retry_clean_a: assert property (resumeValid && resumeRetry |-> !resumeAbort)
		else $error("Retry with abort");
	error_sticky_a: assert property (
		illegalCommandError && !(wr && paddr == PRS_A_STAT && pwdata[2]) |=> illegalCommandError)
		else $error("Error lost");
	illegal_quiet_a: assert property (failed |-> !resumeValid && !$rose(pageRespValid))
		else $error("Illegal command acted");
endmodule : prs_monitor
bind prs_cmd_unit prs_monitor i_prs_monitor (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pageRespValid, .pageRespCode, .pageRespReady, .resumeValid, .resumeRetry,
	.resumeAbort, .illegalCommandError);

// File: prs_partner.sv
// Root complex and stalled client model.
`timescale 1ns/1ps
module prs_partner (
	input wire logic clk, // Clock
	input wire logic slow, // Late accept
	output logic pageRespReady, // Accept
	output logic stallIn, // Stall pulse
	output logic [3:0] stallInTag, // Slot
	output logic [31:0] stallInSid, // Stream
	output logic stallInSec // Security
);
	int seed = 32'h2186;
	logic req = 1'b0;
	logic [36:0] hold = '0;
	initial
	begin
		pageRespReady = 1'b0;
		stallIn = 1'b0;
		{stallInSec, stallInTag, stallInSid} = '0;
	end
	// Released stall lines toggle so stale values never look valid.
	always @(posedge clk)
	begin
		pageRespReady <= !slow || $random(seed) % 2 == 0;
		stallIn <= req && !stallIn;
		{stallInSec, stallInTag, stallInSid} <= (req && !stallIn) ? hold :
			~{stallInSec, stallInTag, stallInSid};
	end
	task automatic stall(input logic [36:0] h);
		hold = h;
		req = 1'b1;
		repeat (2) @(posedge clk);
		req = 1'b0;
	endtask : stall
endmodule : prs_partner

// File: test_page_response_and_stall_resume_cmds.sv
// Self-checking bench of the page response and stall resume unit.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t: %h not %h", $time, a, b); end end
module test_page_response_and_stall_resume_cmds
	import prs_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q, r, s, w0, w1, w2, stallInSid, pageRespSid;
	logic pready, pslverr, stallIn, stallInSec, pageRespValid, pageRespReady, pageRespPasid;
	logic resumeValid, resumeRetry, resumeAbort, illegalCommandError;
	logic [3:0] stallInTag, resumeTag;
	logic [8:0] pageRespGroup, cfg;
	logic [1:0] pageRespCode;
	logic [19:0] pageRespSub;
	logic [63:0] gotPage;
	logic [5:0] gotRes;
	logic vTab [16];
	logic [32:0] sTab [16];
	int seed = 32'h2186, err_count = 0, n_tests = 0, cycles = 0, nPage = 0, nRes = 0;
	prs_cmd_unit i_prs_cmd_unit (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stallIn, .stallInTag, .stallInSid, .stallInSec, .pageRespValid,
		.pageRespSid, .pageRespGroup, .pageRespCode, .pageRespPasid, .pageRespSub, .pageRespReady,
		.resumeValid, .resumeTag, .resumeRetry, .resumeAbort, .illegalCommandError);
	prs_partner i_prs_partner (.clk, .slow, .pageRespReady, .stallIn, .stallInTag, .stallInSid,
		.stallInSec);
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (pageRespValid === 1'b1 && pageRespReady === 1'b1)
		begin
			nPage++;
			gotPage = {pageRespSid, pageRespGroup, pageRespCode, pageRespPasid, pageRespSub};
		end
		if (resumeValid === 1'b1)
		begin
			nRes++;
			gotRes = {resumeTag, resumeRetry, resumeAbort};
		end
		if (cycles == 40000)
		begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		`CHK(pslverr, 1'b0)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task mk(input logic [3:0] t, input logic [32:0] e);
		i_prs_partner.stall({e[32], t, e[31:0]});
		vTab[t] = 1'b1;
		sTab[t] = {e[32] & cfg[PRS_C_SECIMPL], e[31:0]};
	endtask : mk
	function automatic logic [2:0] expOut(input logic sq);
		logic [3:0] t;
		t = w2[3:0];
		if (w0[7:0] == PRS_OP_PAGE_RESP)
		begin
			if (!cfg[PRS_C_PRI] || w2[13:12] == PRS_RESP_RSVD || (sq && cfg[PRS_C_SECURE_ADDR_SERVICES_MASK]))
				return PRS_OUT_ILL;
			return (cfg[PRS_C_SYSPRI] && cfg[PRS_C_EN]) ? PRS_OUT_RESP : PRS_OUT_NOP;
		end
		if (w0[7:0] != PRS_OP_RESUME)
			return PRS_OUT_NONE;
		if (cfg[7:6] == PRS_STALL_UNSUPP || (!sq && w0[PRS_SEC_BIT]))
			return PRS_OUT_ILL;
		if (!vTab[t] || sTab[t] !== {w0[PRS_SEC_BIT], w1})
			return PRS_OUT_NOMATCH;
		if (w2[12])
			return PRS_OUT_RETRY;
		return (cfg[PRS_C_TERM] || w2[13]) ? PRS_OUT_TERM_ABT : PRS_OUT_TERM_OK;
	endfunction : expOut
	task cmd(input logic sq);
		logic [2:0] e;
		int p;
		int n;
		e = expOut(sq);
		p = nPage;
		n = nRes;
		apb(1'b1, PRS_A_CMD0, w0);
		apb(1'b1, PRS_A_CMD1, w1);
		apb(1'b1, PRS_A_CMD2, w2);
		apb(1'b1, PRS_A_CMD3, 32'h0000_0000);
		apb(1'b1, PRS_A_ISSUE, {31'h0, sq});
		q = 32'h0000_0002;
		while (q[1])
			apb(1'b0, PRS_A_STAT, 32'h0000_0000);
		apb(1'b0, PRS_A_LAST, 32'h0000_0000);
		`CHK(q[2:0], e)
		`CHK(illegalCommandError, e == PRS_OUT_ILL)
		`CHK(nPage - p, int'(e == PRS_OUT_RESP))
		`CHK(nRes - n, int'(e inside {[PRS_OUT_RETRY:PRS_OUT_TERM_ABT]}))
		if (e == PRS_OUT_RESP)
		begin
			`CHK(gotPage[63:20], {w1, w2[8:0], w2[13:12], cfg[PRS_C_PASID] & w0[11]})
			if (gotPage[20])
				`CHK(gotPage[19:0], w0[31:12])
		end
		if (e inside {[PRS_OUT_RETRY:PRS_OUT_TERM_ABT]})
		begin
			`CHK(gotRes, {w2[3:0], e == PRS_OUT_RETRY, e == PRS_OUT_TERM_ABT})
			vTab[w2[3:0]] = 1'b0;
		end
		if (illegalCommandError === 1'b1)
			apb(1'b1, PRS_A_STAT, 32'h0000_0004);
	endtask : cmd
	initial
	begin
		foreach (vTab[i])
			vTab[i] = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, PRS_A_CFG, 32'h0000_0000);
		`CHK(q, PRS_CFG_RST)
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		cfg = 9'h100;
		apb(1'b1, PRS_A_CFG, {23'h0, cfg});
		// A secure stall is out of reach of the non-secure queue.
		mk(4'h5, 33'h1_0000_0003);
		w1 = 32'h0000_0003;
		w2 = 32'h0000_1005;
		w0 = {24'h0, PRS_OP_RESUME};
		cmd(1'b0);
		w0[PRS_SEC_BIT] = 1'b1;
		cmd(1'b0);
		cmd(1'b1);
		for (int i = 0; i < 300; i++)
		begin
			r = $random(seed);
			s = $random(seed);
			slow <= r[31];
			if (i % 25 == 0)
			begin
				cfg = {s[23] | s[22], s[31:24]};
				apb(1'b1, PRS_A_CFG, {23'h0, cfg});
			end
			if (r[9])
				mk(r[13:10], {r[16] & r[17], 30'h0, r[15:14]});
			w0 = {s[31:12], r[18], r[29] ? r[16] & r[17] : r[19] & r[20], 2'h0,
				r[21] ? PRS_OP_RESUME : (r[22] | r[23] ? PRS_OP_PAGE_RESP : 8'h00)};
			w1 = {30'h0, r[29] ? r[15:14] : r[26:25]};
			w2 = {18'h0, r[28:27], 3'h0, r[21] ? {5'h0, r[29] ? r[13:10] : s[3:0]} : s[8:0]};
			cmd(r[30]);
		end
		give_verdict();
	end
endmodule : test_page_response_and_stall_resume_cmds
